// ### pkg/ccsc_pkg.sv
// What this block does
// - Status bit 6 shows transfer in progress
// - Status full/overrun bits; parity and framing bits read zero on both channels
// - Mode low bit 0 picks interrupt source
// - Stop trigger one clears enable, halts channel
// - Start trigger one puts channel in standby, or straight into transfer if chip select is already low
// - Operation high bits 7:6 select direction
// - Mask bit one blocks its interrupt
// - Request flag sticks until software clears it
// - Two channels, each with own registers
// - Handshake output low ready, high busy
package ccsc_pkg;
  localparam int CCSC_NCH = 2;
  localparam int CCSC_CHAR_BITS = 8;
  // Per-channel byte offsets inside a channel window, channel stride, shared register addresses
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODE_H = 8'h04;
  localparam logic [7:0] OFS_MODE_L = 8'h08;
  localparam logic [7:0] OFS_OP_H = 8'h0C;
  localparam logic [7:0] OFS_OP_L = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_START = 8'h40;
  localparam logic [7:0] OFS_STOP = 8'h44;
  localparam logic [7:0] OFS_IRQ_REQ = 8'h48;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h4C;
  // Field positions
  localparam int B_ACTIVE = 6;
  localparam int B_BFULL = 5;
  localparam int B_FERR = 2;
  localparam int B_PERR = 1;
  localparam int B_OVR = 0;
  localparam int B_IRQSEL = 0;
  localparam int B_TXE = 7;
  localparam int B_RXE = 6;
  localparam int B_IRQ_CH0 = 3;
  localparam int B_IRQ_CH1 = 4;
  // Reset values
  localparam logic [7:0] RST_MODE_H = 8'h00;
  localparam logic [7:0] RST_MODE_L = 8'h20;
  localparam logic [7:0] RST_OP_H = 8'h00;
  localparam logic [7:0] RST_OP_L = 8'h07;
  localparam logic [7:0] RST_IRQ_REQ = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
  localparam logic [7:0] TX_IDLE = 8'hFF;
  typedef enum logic [1:0] {CCSC_STOP, CCSC_WAIT, CCSC_XFER} ccsc_st_t;
endpackage : ccsc_pkg

// ### logic/ccsc_top.sv
`timescale 1ns/1ps
module ccsc_top
  import ccsc_pkg::*;
(
  input logic pclk, // Bus clock
  input logic presetn, // Async reset, low
  input logic psel, // APB select
  input logic penable, // APB enable
  input logic pwrite, // APB direction
  input logic [7:0] paddr, // APB byte address
  input logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input logic [CCSC_NCH-1:0] sck, // Serial clock from master
  input logic [CCSC_NCH-1:0] cs_n, // Chip select, low
  input logic [CCSC_NCH-1:0] mosi, // Serial data in
  output logic [CCSC_NCH-1:0] miso, // Serial data out
  output logic [CCSC_NCH-1:0] handshake_output_pin, // Low ready, high busy
  output logic irq // Level interrupt
);

  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [7:0] irq_req_q, irq_req_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic acc, commit, wr, rd;
  logic [CCSC_NCH-1:0] ch_hit;
  logic [CCSC_NCH-1:0] ch_ev;
  logic [7:0] ch_rdat [CCSC_NCH];
  logic [CCSC_NCH-1:0] miso_q;
  logic [CCSC_NCH-1:0] busy_q;

  assign acc = psel & penable & ~pready_q;
  assign commit = psel & penable & pready_q;
  assign wr = commit & pwrite;
  assign rd = commit & ~pwrite;

  genvar n;
  generate
    for (n = 0; n < CCSC_NCH; n++)
    begin : g_ch
      logic [2:0] sck_s_q, cs_s_q, mosi_s_q;
      logic sck_f_q, sck_f_d, cs_f_q, cs_f_d, mosi_f_q, mosi_f_d;
      ccsc_st_t st_q, st_d;
      logic [2:0] cnt_q, cnt_d;
      logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
      logic [7:0] tx_buf_q, tx_buf_d, rx_buf_q, rx_buf_d;
      logic bfull_q, bfull_d, rx_full_q, rx_full_d, ovr_q, ovr_d;
      logic [7:0] mode_h_q, mode_h_d, mode_l_q, mode_l_d;
      logic [7:0] op_h_q, op_h_d, op_l_q, op_l_d;
      logic miso_d, busy_d;
      logic in_ch, tx_en, rx_en, loaded, done, ferr;
      logic [7:0] off;

      assign in_ch = (paddr[7:6] == 2'b00) && (paddr[5] == (n == 1));
      assign off = {3'b000, paddr[4:0]};
      // Direction decode: 01 transmit, 10 both, 00 and 11 receive
      assign tx_en = op_h_q[B_TXE] ^ op_h_q[B_RXE];
      assign rx_en = op_h_q[B_TXE] | ~op_h_q[B_RXE];
      assign ferr = 1'b0;

      always_comb
      begin
        // Filtered pin level moves once 2nd and 3rd stages agree
        sck_f_d = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
        cs_f_d = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_f_q;
        mosi_f_d = (mosi_s_q[1] == mosi_s_q[2]) ? mosi_s_q[2] : mosi_f_q;
        st_d = st_q;
        cnt_d = cnt_q;
        tx_sh_d = tx_sh_q;
        rx_sh_d = rx_sh_q;
        tx_buf_d = tx_buf_q;
        rx_buf_d = rx_buf_q;
        bfull_d = bfull_q;
        ovr_d = ovr_q;
        mode_h_d = mode_h_q;
        mode_l_d = mode_l_q;
        op_h_d = op_h_q;
        op_l_d = op_l_q;
        miso_d = miso_q[n];
        loaded = 1'b0;
        done = 1'b0;
        rx_full_d = rx_full_q & ~(rd && in_ch && off == OFS_DATA);
        if (st_q != CCSC_STOP)
        begin
          if (cs_f_d)
          begin
            st_d = CCSC_WAIT;
            cnt_d = 3'd0;
          end
          else if (cs_f_q)
          begin
            st_d = CCSC_XFER;
            loaded = 1'b1;
          end
          else if (st_q == CCSC_XFER && sck_f_d && !sck_f_q)
          begin
            rx_sh_d = {rx_sh_q[6:0], mosi_f_q};
            cnt_d = cnt_q + 3'd1;
            if (cnt_q == 3'(CCSC_CHAR_BITS - 1))
            begin
              done = 1'b1;
              loaded = 1'b1;
            end
          end
          else if (st_q == CCSC_XFER && !sck_f_d && sck_f_q && cnt_q != 3'd0)
          begin
            miso_d = tx_sh_q[6];
            tx_sh_d = {tx_sh_q[6:0], 1'b1};
          end
        end
        if (loaded)
        begin
          if (tx_en && bfull_q)
          begin
            tx_sh_d = tx_buf_q;
            miso_d = tx_buf_q[7];
            bfull_d = 1'b0;
          end
          else
          begin
            tx_sh_d = TX_IDLE;
            miso_d = 1'b1;
            loaded = 1'b0;
          end
        end
        if (done && rx_en)
        begin
          rx_buf_d = {rx_sh_q[6:0], mosi_f_q};
          if (rx_full_d)
          begin
            ovr_d = 1'b1;
          end
          rx_full_d = 1'b1;
        end
        if (wr && in_ch)
        begin
          case (off)
            OFS_MODE_H: mode_h_d = pwdata[7:0];
            OFS_MODE_L: mode_l_d = pwdata[7:0];
            OFS_OP_H: op_h_d = pwdata[7:0];
            OFS_OP_L: op_l_d = pwdata[7:0];
            OFS_DATA:
            begin
              tx_buf_d = pwdata[7:0];
              bfull_d = 1'b1;
            end
            default: ;
          endcase
        end
        if (wr && paddr == OFS_START && pwdata[n])
        begin
          st_d = cs_f_d ? CCSC_WAIT : CCSC_XFER;
          cnt_d = 3'd0;
          ovr_d = 1'b0;
        end
        if (wr && paddr == OFS_STOP && pwdata[n])
        begin
          st_d = CCSC_STOP;
          cnt_d = 3'd0;
        end
        if (st_d == CCSC_STOP)
        begin
          busy_d = 1'b1;
        end
        else
        begin
          busy_d = tx_en ? ~bfull_d : rx_full_d;
        end
      end

      // Interrupt source: end of character or buffer handed off
      assign ch_ev[n] = mode_l_q[B_IRQSEL] ? loaded : done;
      assign ch_hit[n] = in_ch && (off == OFS_STATUS || off == OFS_MODE_H
        || off == OFS_MODE_L || off == OFS_OP_H || off == OFS_OP_L
        || off == OFS_DATA);

      always_comb
      begin
        case (off)
          OFS_STATUS:
          begin
            ch_rdat[n] = 8'h00;
            ch_rdat[n][B_ACTIVE] = (st_q == CCSC_XFER);
            ch_rdat[n][B_BFULL] = bfull_q;
            ch_rdat[n][B_FERR] = (n == 1) ? ferr : 1'b0;
            ch_rdat[n][B_PERR] = 1'b0;
            ch_rdat[n][B_OVR] = ovr_q;
          end
          OFS_MODE_H: ch_rdat[n] = mode_h_q;
          OFS_MODE_L: ch_rdat[n] = mode_l_q;
          OFS_OP_H: ch_rdat[n] = op_h_q;
          OFS_OP_L: ch_rdat[n] = op_l_q;
          OFS_DATA: ch_rdat[n] = rx_buf_q;
          default: ch_rdat[n] = 8'h00;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sck_s_q <= 3'b000;
          cs_s_q <= 3'b111;
          mosi_s_q <= 3'b000;
          sck_f_q <= 1'b0;
          cs_f_q <= 1'b1;
          mosi_f_q <= 1'b0;
          st_q <= CCSC_STOP;
          cnt_q <= 3'd0;
          tx_sh_q <= TX_IDLE;
          rx_sh_q <= 8'h00;
          tx_buf_q <= 8'h00;
          rx_buf_q <= 8'h00;
          bfull_q <= 1'b0;
          rx_full_q <= 1'b0;
          ovr_q <= 1'b0;
          mode_h_q <= RST_MODE_H;
          mode_l_q <= RST_MODE_L;
          op_h_q <= RST_OP_H;
          op_l_q <= RST_OP_L;
          miso_q[n] <= 1'b1;
          busy_q[n] <= 1'b1;
        end
        else
        begin
          sck_s_q <= {sck_s_q[1:0], sck[n]};
          cs_s_q <= {cs_s_q[1:0], cs_n[n]};
          mosi_s_q <= {mosi_s_q[1:0], mosi[n]};
          sck_f_q <= sck_f_d;
          cs_f_q <= cs_f_d;
          mosi_f_q <= mosi_f_d;
          st_q <= st_d;
          cnt_q <= cnt_d;
          tx_sh_q <= tx_sh_d;
          rx_sh_q <= rx_sh_d;
          tx_buf_q <= tx_buf_d;
          rx_buf_q <= rx_buf_d;
          bfull_q <= bfull_d;
          rx_full_q <= rx_full_d;
          ovr_q <= ovr_d;
          mode_h_q <= mode_h_d;
          mode_l_q <= mode_l_d;
          op_h_q <= op_h_d;
          op_l_q <= op_l_d;
          miso_q[n] <= miso_d;
          busy_q[n] <= busy_d;
        end
      end
    end
  endgenerate

  always_comb
  begin
    pready_d = acc;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (acc)
    begin
      prdata_d = 32'h0000_0000;
      if (|ch_hit)
      begin
        prdata_d[7:0] = ch_hit[1] ? ch_rdat[1] : ch_rdat[0];
      end
      else if (paddr == OFS_IRQ_REQ)
      begin
        prdata_d[7:0] = irq_req_q;
      end
      else if (paddr == OFS_IRQ_MASK)
      begin
        prdata_d[7:0] = irq_mask_q;
      end
      else if (paddr != OFS_START && paddr != OFS_STOP)
      begin
        pslverr_d = 1'b1;
      end
    end
    irq_mask_d = irq_mask_q;
    irq_req_d = irq_req_q;
    if (wr && paddr == OFS_IRQ_MASK)
    begin
      irq_mask_d = pwdata[7:0];
    end
    if (wr && paddr == OFS_IRQ_REQ)
    begin
      irq_req_d = irq_req_q & ~pwdata[7:0];
    end
    // Hardware set after the clear, so a same-cycle event survives
    if (ch_ev[0])
    begin
      irq_req_d[B_IRQ_CH0] = 1'b1;
    end
    if (ch_ev[1])
    begin
      irq_req_d[B_IRQ_CH1] = 1'b1;
    end
    irq_d = |(irq_req_q & ~irq_mask_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_req_q <= RST_IRQ_REQ;
      irq_mask_q <= RST_IRQ_MASK;
      irq_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_req_q <= irq_req_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign miso = miso_q;
  assign handshake_output_pin = busy_q;
  assign irq = irq_q;

endmodule : ccsc_top

// ### bench/ccsc_assertions.sv
`timescale 1ns/1ps
module ccsc_assertions
  import ccsc_pkg::*;
(
  input logic pclk, // Clock
  input logic presetn, // Reset
  input logic psel, // Select
  input logic penable, // Enable
  input logic pwrite, // Write
  input logic [7:0] paddr, // Address
  input logic [31:0] pwdata, // Wdata
  input logic [31:0] prdata, // Rdata
  input logic pready, // Ready
  input logic pslverr, // Error
  input logic [CCSC_NCH-1:0] sck, // Clocks
  input logic [CCSC_NCH-1:0] cs_n, // Selects
  input logic [CCSC_NCH-1:0] mosi, // Data in
  input logic [CCSC_NCH-1:0] miso, // Data out
  input logic [CCSC_NCH-1:0] handshake_output_pin, // Busy
  input logic irq // Interrupt
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready unasked");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper bits set");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read nonzero");
  a_rdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved");
  a_irq_sticky: assert property ($fell(irq) |->
    $past(pwrite && pready, 2) || $past(pwrite && pready, 3))
    else $error("irq dropped alone");
  c_error: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_write: cover property (pready && pwrite);
endmodule : ccsc_assertions

// ### bench/ccsc_master_model.sv
`timescale 1ns/1ps
module ccsc_master_model
  import ccsc_pkg::*;
(
  output logic [CCSC_NCH-1:0] sck, // Clocks
  output logic [CCSC_NCH-1:0] cs_n, // Selects
  output logic [CCSC_NCH-1:0] mosi, // Data out
  input logic [CCSC_NCH-1:0] miso, // Data in
  input logic [CCSC_NCH-1:0] handshake_output_pin // Busy
);
  initial
  begin
    sck = '0;
    cs_n = '1;
    mosi = '0;
  end
  task automatic xfer(input int ch, input logic [7:0] tx, output logic [7:0] rx,
    output bit ok);
    int i;
    for (i = 0; i < 200 && handshake_output_pin[ch] !== 1'b0; i++)
      #8;
    ok = (i < 200);
    #5 cs_n[ch] = 1'b0;
    #64;
    for (i = 7; i >= 0; i--)
    begin
      mosi[ch] = tx[i];
      #32 sck[ch] = 1'b1;
      // Sample early in the high phase, before a reload can reach miso
      #16 rx[i] = miso[ch];
      #16 sck[ch] = 1'b0;
    end
    #64 cs_n[ch] = 1'b1;
    mosi[ch] = ~mosi[ch];
  endtask : xfer
endmodule : ccsc_master_model

// ### bench/ccsc_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ccsc_top_tb
  import ccsc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er;
  logic [CCSC_NCH-1:0] sck, cs_n, mosi, miso, hs;
  int fail_count = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  ccsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .handshake_output_pin(hs), .irq(irq));
  ccsc_master_model u_mst (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .handshake_output_pin(hs));
  task automatic results();
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready mid-cycle, where it has settled
    for (k = 0; k < 20; k++)
    begin
      @(negedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      fail_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    // Request stands until the edge at which pready is sampled high
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    `CHK("prdata", e, rd)
    `CHK("pslverr", ee, er)
  endtask : rchk
  task automatic hs_wait(input int ch, input logic v);
    for (int k = 0; k < 60 && hs[ch] !== v; k++)
      @(posedge pclk);
    `CHK("handshake", v, hs[ch])
  endtask : hs_wait
  task automatic t_reset();
    `CHK("handshake", 2'h3, hs)
    rchk(OFS_MODE_L, 32'h20, 1'b0);
    rchk(OFS_OP_L + CH_STRIDE, 32'h07, 1'b0);
    rchk(OFS_IRQ_MASK, 32'hFF, 1'b0);
    apb(1'b1, OFS_STATUS, 8'hFF);
    rchk(OFS_STATUS, 32'h0, 1'b0);
    rchk(OFS_STOP, 32'h0, 1'b0);
    rchk(8'h7C, 32'h0, 1'b1);
  endtask : t_reset
  task automatic t_modes();
    logic [7:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = {2'(i), 6'h00};
      apb(1'b1, OFS_OP_H + CH_STRIDE, c);
      apb(1'b1, OFS_START, 8'h02);
      apb(1'b1, OFS_STOP, 8'h01);
      hs_wait(1, c[7] ^ c[6]);
      apb(1'b1, OFS_STOP, 8'h02);
      hs_wait(1, 1'b1);
    end
  endtask : t_modes
  task automatic t_xfer(input int ch, input logic md);
    logic [7:0] b, m, rx;
    bit ok;
    b = CH_STRIDE * 8'(ch);
    m = 8'h01 << (B_IRQ_CH0 + ch);
    apb(1'b1, OFS_OP_H + b, 8'h80);
    apb(1'b1, OFS_MODE_L + b, {7'h10, md});
    apb(1'b1, OFS_IRQ_MASK, ~m);
    apb(1'b1, OFS_START, 8'h01 << ch);
    apb(1'b1, OFS_DATA + b, 8'hA5);
    hs_wait(ch, 1'b0);
    fork
      u_mst.xfer(ch, 8'h3C, rx, ok);
      begin
        repeat (40) @(posedge pclk);
        rchk(OFS_STATUS + b, 32'h40, 1'b0);
        rchk(OFS_IRQ_REQ, md ? {24'h0, m} : 32'h0, 1'b0);
      end
    join
    `CHK("miso byte", 8'hA5, rx)
    `CHK("ready seen", 1'b1, ok)
    rchk(OFS_DATA + b, 32'h3C, 1'b0);
    rchk(OFS_IRQ_REQ, {24'h0, m}, 1'b0);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, OFS_IRQ_MASK, 8'hFF);
    rchk(OFS_IRQ_REQ, {24'h0, m}, 1'b0);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, OFS_IRQ_REQ, m);
    rchk(OFS_IRQ_REQ, 32'h0, 1'b0);
    apb(1'b1, OFS_STOP, 8'h01 << ch);
    hs_wait(ch, 1'b1);
    rchk(OFS_STATUS + b, 32'h0, 1'b0);
  endtask : t_xfer
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_xfer(0, 1'b0);
    t_xfer(1, 1'b1);
    results();
  end
endmodule : ccsc_top_tb
bind ccsc_top ccsc_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
  .handshake_output_pin(handshake_output_pin), .irq(irq));
